// ### src/rtcal_top.sv
// Dual alarm registers and compare logic.
// Assumes a one-cycle second tick and coherent BCD time beside it.
`timescale 1ns/1ps

module rtcal_top
    import rtcal_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // Register port
    input  wire logic [4:0]  addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // Timekeeping side
    input  wire logic        sec_tick,
    input  wire rtcal_time_s now,
    // Interrupt
    output logic             irq
);

    logic [7:0] a1_sec, a1_min, a1_hrs, a1_daydt, a1_mon, a1_year;
    logic [7:0] a2_min, a2_hrs, a2_daydt;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic       a1_match, a2_match;
    logic       next_a1_event, next_a2_event;

    // Field compare with optional mask
    function automatic logic fld_eq(input logic [7:0] a, input logic [7:0] b,
                                    input logic [7:0] m, input logic msk);
        fld_eq = msk | ((a & m) == (b & m));
    endfunction

    // Day/date compare chosen by the weekday select
    function automatic logic dd_eq(input logic [7:0] r,
                                   input rtcal_time_s t);
        if (r[WDSEL_BIT])
            dd_eq = (r & DAY_FIELD) == (t.day & DAY_FIELD);
        else
            dd_eq = (r & DATE_FIELD) == (t.date & DATE_FIELD);
    endfunction

    // Alarm register writes, reset to zero
    always_ff @(posedge clock) begin
        if (rst) begin
            a1_sec   <= REG_RESET;
            a1_min   <= REG_RESET;
            a1_hrs   <= REG_RESET;
            a1_daydt <= REG_RESET;
            a1_mon   <= REG_RESET;
            a1_year  <= REG_RESET;
            a2_min   <= REG_RESET;
            a2_hrs   <= REG_RESET;
            a2_daydt <= REG_RESET;
        end else if (wr) begin
            case (addr)
                OFS_A1_SEC:   a1_sec   <= wdata;
                OFS_A1_MIN:   a1_min   <= wdata;
                OFS_A1_HRS:   a1_hrs   <= wdata & 8'hBF;
                OFS_A1_DAYDT: a1_daydt <= wdata;
                OFS_A1_MON:   a1_mon   <= wdata & 8'hDF;
                OFS_A1_YEAR:  a1_year  <= wdata;
                OFS_A2_MIN:   a2_min   <= wdata;
                OFS_A2_HRS:   a2_hrs   <= wdata & 8'hBF;
                OFS_A2_DAYDT: a2_daydt <= wdata;
                default: ;
            endcase
        end
    end

    // Hours bit5 is compared as stored: meridiem or twenties alike
    always_comb begin
        a1_match = fld_eq(a1_sec, now.seconds, SEC_FIELD, a1_sec[MASK_BIT])
            & fld_eq(a1_min, now.minutes, SEC_FIELD, a1_min[MASK_BIT])
            & fld_eq(a1_hrs, now.hours, HRS_FIELD, a1_hrs[MASK_BIT])
            & (a1_daydt[MASK_BIT] | dd_eq(a1_daydt, now))
            & fld_eq(a1_mon, now.month, MON_FIELD, a1_mon[MASK_BIT])
            & fld_eq(a1_year, now.year, YEAR_FIELD,
                     a1_mon[YEARMASK_BIT]);
        // Alarm 2 fires on second zero of the selected minute
        a2_match = (now.seconds & SEC_FIELD) == REG_RESET
            & fld_eq(a2_min, now.minutes, SEC_FIELD, a2_min[MASK_BIT])
            & fld_eq(a2_hrs, now.hours, HRS_FIELD, a2_hrs[MASK_BIT])
            & (a2_daydt[MASK_BIT] | dd_eq(a2_daydt, now));
        next_a1_event = sec_tick & a1_match;
        next_a2_event = sec_tick & a2_match;
    end

    // Sticky status, write one clears, set wins
    always_ff @(posedge clock) begin
        if (rst)
            int_stat <= 2'h0;
        else
            int_stat <= (int_stat & ~((wr && addr == OFS_INT_STAT) ?
                        wdata[1:0] : 2'h0))
                        | {next_a2_event, next_a1_event};
    end

    always_ff @(posedge clock) begin
        if (rst)
            int_mask <= 2'h0;
        else if (wr && addr == OFS_INT_MASK)
            int_mask <= wdata[1:0] & IRQ_FIELD;
    end

    assign irq = |(int_stat & int_mask);

    // Read data, one cycle after the strobe
    always_ff @(posedge clock) begin
        if (rst)
            rdata <= 8'h00;
        else if (rd) begin
            case (addr)
                OFS_A1_SEC:   rdata <= a1_sec;
                OFS_A1_MIN:   rdata <= a1_min;
                OFS_A1_HRS:   rdata <= a1_hrs;
                OFS_A1_DAYDT: rdata <= a1_daydt;
                OFS_A1_MON:   rdata <= a1_mon;
                OFS_A1_YEAR:  rdata <= a1_year;
                OFS_A2_MIN:   rdata <= a2_min;
                OFS_A2_HRS:   rdata <= a2_hrs;
                OFS_A2_DAYDT: rdata <= a2_daydt;
                OFS_INT_STAT: rdata <= {6'h00, int_stat};
                OFS_INT_MASK: rdata <= {6'h00, int_mask};
                default:      rdata <= 8'h00;
            endcase
        end else
            rdata <= 8'h00;
    end

    // Checks
    property p_a2_every_minute;
        @(posedge clock) disable iff (rst)
        (sec_tick && a2_min[7] && a2_hrs[7] && a2_daydt[7]
         && now.seconds[6:0] == 7'h00) |=> int_stat[1];
    endproperty
    a_a2_every_minute: assert property (p_a2_every_minute)
        else $error("alarm 2 missed per-minute event");

    property p_a2_min_match;
        @(posedge clock) disable iff (rst)
        (sec_tick && !a2_min[7] && a2_hrs[7] && a2_daydt[7]
         && now.seconds[6:0] == 7'h00 && now.minutes[6:0] == a2_min[6:0])
        |=> int_stat[1];
    endproperty
    a_a2_min_match: assert property (p_a2_min_match)
        else $error("alarm 2 missed minute match");

    property p_a2_hm_mismatch;
        @(posedge clock) disable iff (rst)
        (!int_stat[1] && !a2_hrs[7] && now.hours[5:0] != a2_hrs[5:0]
         && !(wr && addr == OFS_A2_HRS)) |=> !int_stat[1];
    endproperty
    a_a2_hm_mismatch: assert property (p_a2_hm_mismatch)
        else $error("alarm 2 set on hours mismatch");

    property p_a2_date;
        @(posedge clock) disable iff (rst)
        (!int_stat[1] && !a2_daydt[7] && !a2_daydt[6]
         && now.date[5:0] != a2_daydt[5:0]) |=> !int_stat[1];
    endproperty
    a_a2_date: assert property (p_a2_date)
        else $error("alarm 2 set on date mismatch");

    property p_a2_day;
        @(posedge clock) disable iff (rst)
        (!int_stat[1] && !a2_daydt[7] && a2_daydt[6]
         && now.day[2:0] != a2_daydt[2:0]) |=> !int_stat[1];
    endproperty
    a_a2_day: assert property (p_a2_day)
        else $error("alarm 2 set on weekday mismatch");

    property p_no_tick_no_set;
        @(posedge clock) disable iff (rst)
        (!sec_tick && int_stat == 2'h0) |=> int_stat == 2'h0;
    endproperty
    a_no_tick_no_set: assert property (p_no_tick_no_set)
        else $error("alarm flag set without second tick");

    property p_a1_year_mask;
        @(posedge clock) disable iff (rst)
        (!int_stat[0] && !a1_mon[6] && now.year != a1_year)
        |=> !int_stat[0];
    endproperty
    a_a1_year_mask: assert property (p_a1_year_mask)
        else $error("alarm 1 set on year mismatch");

    property p_a1_hours;
        @(posedge clock) disable iff (rst)
        (!int_stat[0] && !a1_hrs[7] && now.hours[5:0] != a1_hrs[5:0])
        |=> !int_stat[0];
    endproperty
    a_a1_hours: assert property (p_a1_hours)
        else $error("alarm 1 set on hours mismatch");

    property p_readback;
        @(posedge clock) disable iff (rst)
        (wr && addr == OFS_A1_YEAR) ##1 !wr
        ##1 (rd && addr == OFS_A1_YEAR && !wr)
        |=> rdata == $past(wdata, 3);
    endproperty
    a_readback: assert property (p_readback)
        else $error("alarm year readback mismatch");

    // Writes land with reserved bits cleared
    property p_a1_sec_write;
        @(posedge clock) disable iff (rst)
        (wr && addr == OFS_A1_SEC) |=> a1_sec == $past(wdata);
    endproperty
    a_a1_sec_write: assert property (p_a1_sec_write)
        else $error("alarm 1 seconds write lost");

    property p_a1_min_write;
        @(posedge clock) disable iff (rst)
        (wr && addr == OFS_A1_MIN) |=> a1_min == $past(wdata);
    endproperty
    a_a1_min_write: assert property (p_a1_min_write)
        else $error("alarm 1 minutes write lost");

    property p_a1_hrs_write;
        @(posedge clock) disable iff (rst)
        (wr && addr == OFS_A1_HRS) |=> a1_hrs == ($past(wdata) & 8'hBF);
    endproperty
    a_a1_hrs_write: assert property (p_a1_hrs_write)
        else $error("alarm 1 hours write wrong");

    property p_a1_daydt_write;
        @(posedge clock) disable iff (rst)
        (wr && addr == OFS_A1_DAYDT) |=> a1_daydt == $past(wdata);
    endproperty
    a_a1_daydt_write: assert property (p_a1_daydt_write)
        else $error("alarm 1 day/date write lost");

    property p_a1_mon_write;
        @(posedge clock) disable iff (rst)
        (wr && addr == OFS_A1_MON) |=> a1_mon == ($past(wdata) & 8'hDF);
    endproperty
    a_a1_mon_write: assert property (p_a1_mon_write)
        else $error("alarm 1 month write wrong");

    property p_a1_year_write;
        @(posedge clock) disable iff (rst)
        (wr && addr == OFS_A1_YEAR) |=> a1_year == $past(wdata);
    endproperty
    a_a1_year_write: assert property (p_a1_year_write)
        else $error("alarm 1 year write lost");

    property p_a2_min_write;
        @(posedge clock) disable iff (rst)
        (wr && addr == OFS_A2_MIN) |=> a2_min == $past(wdata);
    endproperty
    a_a2_min_write: assert property (p_a2_min_write)
        else $error("alarm 2 minutes write lost");

    property p_a2_hrs_write;
        @(posedge clock) disable iff (rst)
        (wr && addr == OFS_A2_HRS) |=> a2_hrs == ($past(wdata) & 8'hBF);
    endproperty
    a_a2_hrs_write: assert property (p_a2_hrs_write)
        else $error("alarm 2 hours write wrong");

    property p_a2_daydt_write;
        @(posedge clock) disable iff (rst)
        (wr && addr == OFS_A2_DAYDT) |=> a2_daydt == $past(wdata);
    endproperty
    a_a2_daydt_write: assert property (p_a2_daydt_write)
        else $error("alarm 2 day/date write lost");

    // Reset clears every field and the status
    property p_reset_clear;
        @(posedge clock)
        rst |=> (a1_sec == REG_RESET && a1_min == REG_RESET
                 && a1_hrs == REG_RESET && a1_daydt == REG_RESET
                 && a1_mon == REG_RESET && a1_year == REG_RESET
                 && a2_min == REG_RESET && a2_hrs == REG_RESET
                 && a2_daydt == REG_RESET && int_stat == 2'h0
                 && rdata == 8'h00);
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("register not cleared by reset");

    property p_rdata_idle;
        @(posedge clock) disable iff (rst)
        !rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read slot");

    // Unmasked alarm 1 field mismatches and alarm 2 minute mismatches never raise their flag
    property p_a1_sec_mismatch;
        @(posedge clock) disable iff (rst)
        (!int_stat[0] && !a1_sec[7] && now.seconds[6:0] != a1_sec[6:0])
        |=> !int_stat[0];
    endproperty
    a_a1_sec_mismatch: assert property (p_a1_sec_mismatch)
        else $error("alarm 1 set on seconds mismatch");

    property p_a1_min_mismatch;
        @(posedge clock) disable iff (rst)
        (!int_stat[0] && !a1_min[7] && now.minutes[6:0] != a1_min[6:0])
        |=> !int_stat[0];
    endproperty
    a_a1_min_mismatch: assert property (p_a1_min_mismatch)
        else $error("alarm 1 set on minutes mismatch");

    property p_a1_date_mismatch;
        @(posedge clock) disable iff (rst)
        (!int_stat[0] && !a1_daydt[7] && !a1_daydt[6]
         && now.date[5:0] != a1_daydt[5:0]) |=> !int_stat[0];
    endproperty
    a_a1_date_mismatch: assert property (p_a1_date_mismatch)
        else $error("alarm 1 set on date mismatch");

    property p_a1_day_mismatch;
        @(posedge clock) disable iff (rst)
        (!int_stat[0] && !a1_daydt[7] && a1_daydt[6]
         && now.day[2:0] != a1_daydt[2:0]) |=> !int_stat[0];
    endproperty
    a_a1_day_mismatch: assert property (p_a1_day_mismatch)
        else $error("alarm 1 set on weekday mismatch");

    property p_a1_month_mismatch;
        @(posedge clock) disable iff (rst)
        (!int_stat[0] && !a1_mon[7] && now.month[4:0] != a1_mon[4:0])
        |=> !int_stat[0];
    endproperty
    a_a1_month_mismatch: assert property (p_a1_month_mismatch)
        else $error("alarm 1 set on month mismatch");

    property p_a2_min_mismatch;
        @(posedge clock) disable iff (rst)
        (!int_stat[1] && !a2_min[7] && now.minutes[6:0] != a2_min[6:0])
        |=> !int_stat[1];
    endproperty
    a_a2_min_mismatch: assert property (p_a2_min_mismatch)
        else $error("alarm 2 set on minutes mismatch");

    // Status flag: match on a tick sets it, even against a clear
    property p_a1_set;
        @(posedge clock) disable iff (rst)
        (sec_tick && a1_match) |=> int_stat[0];
    endproperty
    a_a1_set: assert property (p_a1_set)
        else $error("alarm 1 match did not set flag");

    property p_a1_clear;
        @(posedge clock) disable iff (rst)
        (wr && addr == OFS_INT_STAT && wdata[0] && !next_a1_event)
        |=> !int_stat[0];
    endproperty
    a_a1_clear: assert property (p_a1_clear)
        else $error("alarm 1 flag not cleared");

    c_a1_fire: cover property (@(posedge clock) disable iff (rst)
        next_a1_event);
    c_a2_fire: cover property (@(posedge clock) disable iff (rst)
        next_a2_event);
    c_irq: cover property (@(posedge clock) disable iff (rst) irq);
    c_set_clear: cover property (@(posedge clock) disable iff (rst)
        next_a1_event && wr && addr == OFS_INT_STAT);

endmodule

// ### src/rtcal_pkg.sv
// Package for the dual alarm compare block: offsets, fields, types.
// Assumes BCD time inputs from the timekeeping counters.
package rtcal_pkg;

    localparam int          ADDR_W        = 5;
    localparam logic [4:0]  OFS_A1_SEC    = 5'h10;
    localparam logic [4:0]  OFS_A1_MIN    = 5'h11;
    localparam logic [4:0]  OFS_A1_HRS    = 5'h12;
    localparam logic [4:0]  OFS_A1_DAYDT  = 5'h13;
    localparam logic [4:0]  OFS_A1_MON    = 5'h14;
    localparam logic [4:0]  OFS_A1_YEAR   = 5'h15;
    localparam logic [4:0]  OFS_A2_MIN    = 5'h16;
    localparam logic [4:0]  OFS_A2_HRS    = 5'h17;
    localparam logic [4:0]  OFS_A2_DAYDT  = 5'h18;
    localparam logic [4:0]  OFS_INT_STAT  = 5'h01;
    localparam logic [4:0]  OFS_INT_MASK  = 5'h02;

    localparam int          MASK_BIT      = 7;
    localparam int          YEARMASK_BIT  = 6;
    localparam int          WDSEL_BIT     = 6;
    localparam int          FMT12_BIT     = 6;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [7:0]  SEC_FIELD     = 8'h7F;
    localparam logic [7:0]  HRS_FIELD     = 8'h3F;
    localparam logic [7:0]  DAYDT_FIELD   = 8'h3F;
    localparam logic [7:0]  DATE_FIELD    = 8'h3F;
    localparam logic [7:0]  DAY_FIELD     = 8'h07;
    localparam logic [7:0]  MON_FIELD     = 8'h1F;
    localparam logic [7:0]  YEAR_FIELD    = 8'hFF;
    localparam logic [1:0]  IRQ_FIELD     = 2'h3;

    // Current time from the timekeeping counters, BCD.
    typedef struct packed {
        logic [7:0] seconds;
        logic [7:0] minutes;
        logic [7:0] hours;
        logic [7:0] day;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } rtcal_time_s;

    // Register bus request.
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } rtcal_bus_s;

endpackage

// ### test/rtcal_top_bench.sv
// Self-checking bench for the dual alarm registers and compare logic.
// Assumes rtcal_pkg and rtcal_top are compiled first; one 200 MHz clock.
`timescale 1ns/1ps
module rtcal_top_bench
    import rtcal_pkg::*;
;
    typedef struct packed {
        logic [71:0] r;
        logic [55:0] t;
        logic [1:0]  e;
    } rtcal_case_s;

    logic        clock = 1'b0;
    logic        rst;
    logic [4:0]  addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic [7:0]  rdata;
    logic        sec_tick;
    rtcal_time_s now;
    logic        irq;
    logic [7:0]  exp_q[$];
    int          failures = 0;
    int          check_count = 0;
    int          cycles = 0;
    // Readable bits per register, 0x10 to 0x18
    logic [7:0]  fmask[9] = '{8'hFF, 8'hFF, 8'hBF, 8'hFF, 8'hDF,
                              8'hFF, 8'hFF, 8'hBF, 8'hFF};
    // Registers 0x10..0x18, time, expected status bits
    rtcal_case_s cases[25] = '{
        // Second alarm rates
        '{72'h59_00_00_00_00_00_80_80_C0, 56'h00_33_00_00_00_00_00, 2'h2},
        '{72'h59_00_00_00_00_00_80_80_80, 56'h01_33_00_00_00_00_00, 2'h0},
        '{72'h59_00_00_00_00_00_25_80_80, 56'h00_25_00_00_00_00_00, 2'h2},
        '{72'h59_00_00_00_00_00_25_80_80, 56'h00_24_00_00_00_00_00, 2'h0},
        '{72'h59_00_00_00_00_00_25_13_80, 56'h00_25_13_00_00_00_00, 2'h2},
        '{72'h59_00_00_00_00_00_25_13_80, 56'h00_25_12_00_00_00_00, 2'h0},
        '{72'h59_00_00_00_00_00_25_13_21, 56'h00_25_13_05_21_00_00, 2'h2},
        '{72'h59_00_00_00_00_00_25_13_21, 56'h00_25_13_05_22_00_00, 2'h0},
        '{72'h59_00_00_00_00_00_25_13_45, 56'h00_25_13_05_22_00_00, 2'h2},
        '{72'h59_00_00_00_00_00_25_13_45, 56'h00_25_13_06_21_00_00, 2'h0},
        // Meridiem bit compared in 12-hour mode
        '{72'h59_00_00_00_00_00_25_21_80, 56'h00_25_61_00_00_00_00, 2'h2},
        '{72'h59_00_00_00_00_00_25_21_80, 56'h00_25_41_00_00_00_00, 2'h0},
        // First alarm field masks
        '{72'h80_80_80_80_C0_00_80_80_80, 56'h30_00_00_00_00_00_00, 2'h1},
        '{72'h30_80_80_80_C0_00_80_80_80, 56'h30_00_00_00_00_00_00, 2'h1},
        '{72'h30_80_80_80_C0_00_80_80_80, 56'h31_00_00_00_00_00_00, 2'h0},
        '{72'h80_80_15_80_C0_00_80_80_80, 56'h30_00_15_00_00_00_00, 2'h1},
        '{72'h80_80_15_80_C0_00_80_80_80, 56'h30_00_14_00_00_00_00, 2'h0},
        '{72'h80_80_80_12_C0_00_80_80_80, 56'h30_00_00_00_12_00_00, 2'h1},
        '{72'h80_80_80_12_C0_00_80_80_80, 56'h30_00_00_00_13_00_00, 2'h0},
        '{72'h80_80_80_43_C0_00_80_80_80, 56'h30_00_00_03_13_00_00, 2'h1},
        '{72'h80_80_80_43_C0_00_80_80_80, 56'h30_00_00_04_03_00_00, 2'h0},
        '{72'h80_80_80_80_52_00_80_80_80, 56'h30_00_00_00_00_12_00, 2'h1},
        '{72'h80_80_80_80_52_00_80_80_80, 56'h30_00_00_00_00_11_00, 2'h0},
        '{72'h80_80_80_80_80_47_80_80_80, 56'h30_00_00_00_00_00_47, 2'h1},
        '{72'h80_80_80_80_80_47_80_80_80, 56'h30_00_00_00_00_00_48, 2'h0}
    };

    rtcal_top dut (
        .clock    (clock),
        .rst      (rst),
        .addr     (addr),
        .wdata    (wdata),
        .wr       (wr),
        .rd       (rd),
        .rdata    (rdata),
        .sec_tick (sec_tick),
        .now      (now),
        .irq      (irq)
    );

    always #2.5 clock = ~clock;

    task automatic err(input string m);
        failures++;
        $display("Error at %0t: %s", $time, m);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err($sformatf("got %h expected %h", got, exp));
        end
    endtask

    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clock);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock);
        wr    <= 1'b0;
    endtask

    // Issues a read and leaves the expected data for the monitor
    task automatic rd_reg(input logic [4:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd   <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        rd   <= 1'b0;
    endtask

    task automatic tick(input rtcal_time_s t);
        @(posedge clock);
        now      <= t;
        sec_tick <= 1'b1;
        @(posedge clock);
        sec_tick <= 1'b0;
        #1;
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge clock) begin
        if (rd) begin
            @(negedge clock);
            if (exp_q.size() == 0) begin
                err("read data with no expectation");
            end else begin
                chk(rdata, exp_q.pop_front());
            end
        end
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err("timeout");
            report_and_stop();
        end
    end

    initial begin
        logic [7:0] d;
        rst      = 1'b1;
        addr     = 5'h00;
        wdata    = 8'h00;
        wr       = 1'b0;
        rd       = 1'b0;
        sec_tick = 1'b0;
        now      = '0;
        void'($urandom(84));
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            rd_reg(5'(16 + i), 8'h00);
        end
        rd_reg(OFS_INT_STAT, 8'h00);
        for (int i = 0; i < 9; i++) begin
            d = 8'($urandom);
            wr_reg(5'(16 + i), d);
            rd_reg(5'(16 + i), d & fmask[i]);
        end
        wr_reg(5'h1F, 8'hA5);
        rd_reg(5'h1F, 8'h00);
        wr_reg(OFS_INT_MASK, 8'h03);
        rd_reg(OFS_INT_MASK, 8'h03);
        foreach (cases[k]) begin
            for (int i = 0; i < 9; i++) begin
                wr_reg(5'(16 + i), cases[k].r[71 - 8 * i -: 8]);
            end
            tick(cases[k].t);
            chk({7'h00, irq}, {7'h00, |cases[k].e});
            rd_reg(OFS_INT_STAT, {6'h00, cases[k].e});
            wr_reg(OFS_INT_STAT, 8'h03);
        end
        // Masked event stays in status, irq follows mask and clear
        wr_reg(OFS_INT_MASK, 8'h00);
        tick(cases[0].t);
        chk({7'h00, irq}, 8'h00);
        rd_reg(OFS_INT_STAT, 8'h02);
        wr_reg(OFS_INT_MASK, 8'h02);
        #1;
        chk({7'h00, irq}, 8'h01);
        wr_reg(OFS_INT_STAT, 8'h02);
        #1;
        chk({7'h00, irq}, 8'h00);
        rd_reg(OFS_INT_STAT, 8'h00);
        repeat (4) @(posedge clock);
        report_and_stop();
    end
endmodule
